// File: logic/pps_consts.vh
// Constants shared by the push-pull PWM sequencer: register map, events, timing.
// Assumes a 100 MHz clk; voltages and currents are carried as integer millivolts.
//
// Behaviour
// RULE_01: Each gate drive switches at half the cycle rate, at most 50% duty.
// RULE_02: After one output turns off, wait programmable dead time before other turns on.
// RULE_03: Both gate drive outputs are never high together.
// RULE_04: Dead time setting of zero adds no extra dead time, allowing full 50%. The code still keeps a one-clock gap.
// RULE_05: External clock must run at least 25% above internal oscillator to lock.
// RULE_06: Unused external clock input is held low to run from internal oscillator.
// RULE_07: Each current limit trip adds one fixed charge step to the fault integrator.
// RULE_08: Integrator at shutdown threshold stops both outputs and enters fault shutdown.
// RULE_09: In fault, integrator bled to restart threshold starts a fresh soft-start.
// RULE_10: Current sense is compared against fixed current limit level every cycle.
// RULE_11: Current limit trip ends the active on-time within that same cycle.
// RULE_12: Soft-start begins only after undervoltage lockout is released.
// RULE_13: Soft-start reference steps from zero to 1230 mV over 2047 cycles, then holds.
// RULE_14: Slope ramp restarts from zero each cycle and rises at programmed rate.
// RULE_15: Output turns off when sense exceeds error level minus 1600 mV minus ramp.
// RULE_16: Undervoltage lockout holds oscillator, comparators and both drivers inactive.
// RULE_17: A steering flip-flop toggles each cycle so outputs take turns.
// RULE_18: An active external clock's rising edges start each cycle instead.
`ifndef PPS_CONSTS_VH
`define PPS_CONSTS_VH

`define PPS_OFS_OSC_PERIOD 12'h000
`define PPS_OFS_DEAD_TIME 12'h004
`define PPS_OFS_SLOPE 12'h008
`define PPS_OFS_BLEED 12'h00c
`define PPS_OFS_STATUS 12'h010
`define PPS_OFS_LEVELS 12'h014
`define PPS_OFS_IRQ_STATUS 12'h018
`define PPS_OFS_IRQ_CLEAR 12'h01c
`define PPS_OFS_IRQ_ENABLE 12'h020

`define PPS_RST_OSC_PERIOD 16'h00c8
`define PPS_RST_DEAD_TIME 16'h0003
`define PPS_RST_SLOPE 16'h0001
`define PPS_RST_BLEED 16'h0064
`define PPS_MIN_OSC_PERIOD 16'h0004

`define PPS_CLK_MHZ 100
`define PPS_DEAD_MIN_NS 30
// The dead-time floor in whole clocks, rounded up so it never falls short of the minimum.
`define PPS_DEAD_MIN_CYC 16'h0003

`define PPS_CURRENT_LIMIT_COMPARATOR_MV 16'h013a
`define PPS_OFFSET_MV 16'h0640
`define PPS_FI_STEP 16'h003c
`define PPS_FI_SHUT 16'h0af0
`define PPS_FI_RESTART 16'h0640
`define PPS_SS_CYCLES 11'h7ff
`define PPS_REF_MV 11'h4ce

`define PPS_EV_CURRENT_LIMIT_COMPARATOR 0
`define PPS_EV_FAULT 1
`define PPS_EV_RESTART 2
`define PPS_EV_SS_DONE 3
`define PPS_NUM_EV 4

`endif

// File: logic/pps_sequencer.v
// Timing core of a current-mode push-pull PWM controller with an APB register slave.
// Assumes comparator inputs in millivolts from same-clock converters; sync and lockout pins
// are asynchronous and are filtered here.
`timescale 1ns/1ps
`include "pps_consts.vh"

module pps_sequencer
(
    input wire clk,
    input wire sys_rst,
    input wire undervoltage_lockout,
    input wire ext_sync,
    input wire [15:0] current_sense_mv,
    input wire [15:0] error_amp_mv,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg first_gate_drive,
    output reg second_gate_drive,
    output reg [10:0] soft_start_reference,
    output reg fault_shutdown,
    output reg irq
);

    localparam ST_HOLD = 2'b00;
    localparam ST_SOFT = 2'b01;
    localparam ST_RUN = 2'b10;
    localparam ST_FAULT = 2'b11;

    reg [15:0] osc_period;
    reg [15:0] dead_time_setting;
    reg [15:0] slope_ramp_setting;
    reg [15:0] bleed_period;
    reg [`PPS_NUM_EV-1:0] irq_status;
    reg [`PPS_NUM_EV-1:0] irq_enable;

    reg [1:0] pin_s1;
    reg [1:0] pin_s2;
    reg [1:0] pin_s3;
    reg [1:0] pin_f;
    reg sync_prev;

    reg [1:0] state;
    reg [15:0] osc_cnt;
    reg [16:0] sync_wd;
    reg steer;
    reg tripped;
    reg [15:0] dead_cnt;
    reg [15:0] ramp_mv;
    reg [15:0] integ;
    reg [15:0] bleed_cnt;
    reg [10:0] ss_cnt;

    reg [1:0] next_state;
    reg [`PPS_NUM_EV-1:0] events;

    wire [1:0] pin_raw;
    wire undervoltage_lockout_f;
    wire sync_f;
    wire sync_edge;
    wire sync_active;
    wire [15:0] period_eff;
    wire [15:0] dead_eff;
    wire int_tick;
    wire cycle_start;
    wire running;
    wire any_on;
    wire current_limit_comparator_now;
    wire [17:0] pwm_lhs;
    wire pwm_now;
    wire trip_now;
    wire next_steer;
    wire next_tripped;
    wire next_first;
    wire next_second;
    wire off_event;
    wire [16:0] integ_sum;
    wire bleed_tick;
    wire [21:0] ref_prod;
    wire apb_setup;
    wire apb_done;
    wire apb_wr;
    wire addr_ok;
    wire [`PPS_NUM_EV-1:0] irq_clear;

    assign pin_raw = {undervoltage_lockout, ext_sync};

    // Three stages per pin; a new level is accepted only when the second and third agree.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_pin
            always @(posedge clk)
            begin
                if (sys_rst)
                begin
                    pin_s1[gi] <= 1'b0;
                    pin_s2[gi] <= 1'b0;
                    pin_s3[gi] <= 1'b0;
                    pin_f[gi] <= 1'b0;
                end
                else
                begin
                    pin_s1[gi] <= pin_raw[gi];
                    pin_s2[gi] <= pin_s1[gi];
                    pin_s3[gi] <= pin_s2[gi];
                    if (pin_s2[gi] == pin_s3[gi])
                    begin
                        pin_f[gi] <= pin_s3[gi];
                    end
                end
            end
        end
    endgenerate

    assign sync_f = pin_f[0];
    assign undervoltage_lockout_f = pin_f[1];
    assign sync_edge = sync_f & ~sync_prev;

    // Periods below the minimum would leave no room for dead time and a pulse.
    assign period_eff = (osc_period < `PPS_MIN_OSC_PERIOD) ? `PPS_MIN_OSC_PERIOD : osc_period;

    // Zero selects the no-extra-dead-time mode; other values are clamped to the
    // 30 ns floor and to one oscillator period, which is half a switching period.
    assign dead_eff = (dead_time_setting == 16'h0000) ? 16'h0000 : // RULE_04
                      (dead_time_setting < `PPS_DEAD_MIN_CYC) ? `PPS_DEAD_MIN_CYC : // RULE_02
                      (dead_time_setting > period_eff) ? period_eff : dead_time_setting;

    // A sync edge keeps the source selected for two internal periods; only a clock slower
    // than half the internal rate would let internal ticks slip in, so 25% leaves wide margin.
    assign sync_active = (sync_wd < {period_eff, 1'b0}); // RULE_05
    assign int_tick = (osc_cnt >= period_eff - 16'h0001);
    assign running = (state == ST_SOFT) || (state == ST_RUN);
    assign cycle_start = (state != ST_HOLD) &&
                         (sync_active ? sync_edge : int_tick); // RULE_18

    assign any_on = first_gate_drive | second_gate_drive;
    assign current_limit_comparator_now = (current_sense_mv > `PPS_CURRENT_LIMIT_COMPARATOR_MV); // RULE_10
    assign pwm_lhs = {2'b00, current_sense_mv} + {2'b00, `PPS_OFFSET_MV} + {2'b00, ramp_mv};
    assign pwm_now = (pwm_lhs > {2'b00, error_amp_mv}); // RULE_15
    assign trip_now = any_on & (current_limit_comparator_now | pwm_now); // RULE_11

    assign next_steer = cycle_start ? ~steer : steer; // RULE_17
    assign next_tripped = cycle_start ? 1'b0 : (tripped | trip_now);

    // Each output is eligible only in its own oscillator period, so it can be high for
    // at most one period of every two: 50% at half the oscillator rate.
    assign next_first = running & ~next_steer & ~next_tripped & // RULE_01
                        (first_gate_drive | (~second_gate_drive & (dead_cnt == 16'h0000))); // RULE_03
    assign next_second = running & next_steer & ~next_tripped &
                         (second_gate_drive | (~first_gate_drive & (dead_cnt == 16'h0000))); // RULE_03
    assign off_event = (first_gate_drive & ~next_first) | (second_gate_drive & ~next_second);

    assign integ_sum = {1'b0, integ} + {1'b0, `PPS_FI_STEP};
    assign bleed_tick = (bleed_cnt >= bleed_period) && (bleed_period != 16'h0000);
    assign ref_prod = {11'h000, ss_cnt} * {11'h000, `PPS_REF_MV};

    assign apb_setup = psel & penable & ~pready;
    assign apb_done = psel & penable & pready;
    assign apb_wr = apb_done & pwrite & ~pslverr;
    assign addr_ok = (paddr == `PPS_OFS_OSC_PERIOD) || (paddr == `PPS_OFS_DEAD_TIME) ||
                     (paddr == `PPS_OFS_SLOPE) || (paddr == `PPS_OFS_BLEED) ||
                     (paddr == `PPS_OFS_STATUS) || (paddr == `PPS_OFS_LEVELS) ||
                     (paddr == `PPS_OFS_IRQ_STATUS) || (paddr == `PPS_OFS_IRQ_CLEAR) ||
                     (paddr == `PPS_OFS_IRQ_ENABLE);
    assign irq_clear = (apb_wr && (paddr == `PPS_OFS_IRQ_CLEAR)) ?
                       pwdata[`PPS_NUM_EV-1:0] : {`PPS_NUM_EV{1'b0}};

    always @*
    begin
        next_state = state;
        events = {`PPS_NUM_EV{1'b0}};
        events[`PPS_EV_CURRENT_LIMIT_COMPARATOR] = any_on & current_limit_comparator_now & ~tripped;
        case (state)
            ST_HOLD:
            begin
                next_state = ST_SOFT; // RULE_12
            end
            ST_SOFT:
            begin
                if (integ >= `PPS_FI_SHUT)
                begin
                    next_state = ST_FAULT;
                    events[`PPS_EV_FAULT] = 1'b1;
                end
                else if (cycle_start && (ss_cnt == `PPS_SS_CYCLES - 11'h001))
                begin
                    next_state = ST_RUN;
                    events[`PPS_EV_SS_DONE] = 1'b1;
                end
            end
            ST_RUN:
            begin
                if (integ >= `PPS_FI_SHUT) // RULE_08
                begin
                    next_state = ST_FAULT;
                    events[`PPS_EV_FAULT] = 1'b1;
                end
            end
            ST_FAULT:
            begin
                if (integ <= `PPS_FI_RESTART) // RULE_09
                begin
                    next_state = ST_SOFT;
                    events[`PPS_EV_RESTART] = 1'b1;
                end
            end
            default:
            begin
                next_state = ST_HOLD;
            end
        endcase
    end

    // Lockout acts like a synchronous reset on the whole switching core.
    always @(posedge clk)
    begin
        if (sys_rst || undervoltage_lockout_f) // RULE_16
        begin
            state <= ST_HOLD;
            osc_cnt <= 16'h0000;
            sync_wd <= 17'h1ffff;
            sync_prev <= 1'b0;
            steer <= 1'b1;
            tripped <= 1'b0;
            dead_cnt <= 16'h0000;
            ramp_mv <= 16'h0000;
            ss_cnt <= 11'h000;
            first_gate_drive <= 1'b0;
            second_gate_drive <= 1'b0;
            soft_start_reference <= 11'h000;
            fault_shutdown <= 1'b0;
        end
        else
        begin
            state <= next_state;
            sync_prev <= sync_f;
            osc_cnt <= (cycle_start || int_tick) ? 16'h0000 : osc_cnt + 16'h0001;
            if (sync_edge)
            begin
                sync_wd <= 17'h00000;
            end
            else if (sync_wd != 17'h1ffff)
            begin
                sync_wd <= sync_wd + 17'h00001;
            end
            steer <= next_steer;
            tripped <= next_tripped;
            first_gate_drive <= next_first;
            second_gate_drive <= next_second;
            if (off_event)
            begin
                dead_cnt <= dead_eff; // RULE_02
            end
            else if (dead_cnt != 16'h0000)
            begin
                dead_cnt <= dead_cnt - 16'h0001;
            end
            if (cycle_start)
            begin
                ramp_mv <= 16'h0000; // RULE_14
            end
            else if (ramp_mv <= 16'hffff - slope_ramp_setting)
            begin
                ramp_mv <= ramp_mv + slope_ramp_setting;
            end
            if (next_state != ST_SOFT)
            begin
                ss_cnt <= (next_state == ST_RUN) ? `PPS_SS_CYCLES : 11'h000;
            end
            else if (cycle_start && (ss_cnt != `PPS_SS_CYCLES))
            begin
                ss_cnt <= ss_cnt + 11'h001; // RULE_13
            end
            if (ss_cnt == `PPS_SS_CYCLES)
            begin
                soft_start_reference <= `PPS_REF_MV;
            end
            else
            begin
                soft_start_reference <= ref_prod[21:11];
            end
            fault_shutdown <= (next_state == ST_FAULT);
        end
    end

    // The integrator survives lockout, but release goes straight to soft-start; fault returns only if it is still at the shutdown threshold.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            integ <= 16'h0000;
            bleed_cnt <= 16'h0000;
        end
        else
        begin
            bleed_cnt <= bleed_tick ? 16'h0000 : bleed_cnt + 16'h0001;
            if (events[`PPS_EV_CURRENT_LIMIT_COMPARATOR])
            begin
                integ <= integ_sum[16] ? 16'hffff : integ_sum[15:0]; // RULE_07
            end
            else if (bleed_tick && (integ != 16'h0000))
            begin
                integ <= integ - 16'h0001;
            end
        end
    end

    // One wait state lets read data come straight from a flip-flop.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            osc_period <= `PPS_RST_OSC_PERIOD;
            dead_time_setting <= `PPS_RST_DEAD_TIME;
            slope_ramp_setting <= `PPS_RST_SLOPE;
            bleed_period <= `PPS_RST_BLEED;
            irq_enable <= {`PPS_NUM_EV{1'b0}};
            irq_status <= {`PPS_NUM_EV{1'b0}};
            irq <= 1'b0;
        end
        else
        begin
            pready <= apb_setup;
            pslverr <= apb_setup & ~addr_ok;
            if (apb_setup)
            begin
                case (paddr)
                    `PPS_OFS_OSC_PERIOD: prdata <= {16'h0000, osc_period};
                    `PPS_OFS_DEAD_TIME: prdata <= {16'h0000, dead_time_setting};
                    `PPS_OFS_SLOPE: prdata <= {16'h0000, slope_ramp_setting};
                    `PPS_OFS_BLEED: prdata <= {16'h0000, bleed_period};
                    `PPS_OFS_STATUS: prdata <= {24'h000000, sync_active, steer,
                                                second_gate_drive, first_gate_drive,
                                                undervoltage_lockout_f, fault_shutdown, state};
                    `PPS_OFS_LEVELS: prdata <= {5'h00, ss_cnt, integ};
                    `PPS_OFS_IRQ_STATUS: prdata <= {28'h0000000, irq_status};
                    `PPS_OFS_IRQ_ENABLE: prdata <= {28'h0000000, irq_enable};
                    default: prdata <= 32'h00000000;
                endcase
            end
            if (apb_wr)
            begin
                case (paddr)
                    `PPS_OFS_OSC_PERIOD: osc_period <= pwdata[15:0];
                    `PPS_OFS_DEAD_TIME: dead_time_setting <= pwdata[15:0];
                    `PPS_OFS_SLOPE: slope_ramp_setting <= pwdata[15:0];
                    `PPS_OFS_BLEED: bleed_period <= pwdata[15:0];
                    `PPS_OFS_IRQ_ENABLE: irq_enable <= pwdata[`PPS_NUM_EV-1:0];
                    default: irq_enable <= irq_enable;
                endcase
            end
            // A new event in the clearing cycle stays set.
            irq_status <= (irq_status & ~irq_clear) | events;
            irq <= |(((irq_status & ~irq_clear) | events) & irq_enable);
        end
    end

endmodule // pps_sequencer

// File: testbench/pps_partner.sv
// Far side of the sequencer: an optional external clock source and two power switch gates.
// Assumes gates are on while high and the clock source runs freely while enabled.
`timescale 1ns/1ps
module pps_partner
(
    input wire clk,
    input wire sync_on,
    input wire [15:0] sync_period,
    input wire first_gate_drive,
    input wire second_gate_drive,
    output reg ext_sync,
    output reg shoot_through
);
    reg [15:0] cnt = 16'h0000;
    initial ext_sync = 1'b0;
    initial shoot_through = 1'b0;
    always @(posedge clk)
    begin
        // The bench picks a period well over 25% shorter than the internal one.
        cnt <= (!sync_on || cnt + 16'h0001 >= sync_period) ? 16'h0000 : cnt + 16'h0001;
        // An unused source is tied to ground, never left floating.
        ext_sync <= sync_on && (cnt < (sync_period >> 1));
        if (first_gate_drive && second_gate_drive)
            shoot_through <= 1'b1;
    end
endmodule // pps_partner

// File: testbench/pps_sequencer_assertions.sv
// Port checker for the sequencer, bound to every instance.
// Assumes the bench keeps the oscillator period at or below ON_MAX clocks.
`timescale 1ns/1ps
module pps_sequencer_checker
(
    input wire clk,
    input wire sys_rst,
    input wire undervoltage_lockout,
    input wire [15:0] current_sense_mv,
    input wire [15:0] error_amp_mv,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire first_gate_drive,
    input wire second_gate_drive,
    input wire [10:0] soft_start_reference,
    input wire fault_shutdown
);
    localparam int ON_MAX = 200;
    reg [2:0] uv_cnt;
    reg [8:0] on_cnt;
    wire on_any = first_gate_drive || second_gate_drive;
    wire trip = current_sense_mv > 16'h013a ||
        {1'b0, current_sense_mv} + 17'h00640 > {1'b0, error_amp_mv};
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    always @(posedge clk)
    begin
        // The lockout pin is filtered inside, so only a long-held lockout is judged.
        uv_cnt <= (sys_rst || !undervoltage_lockout) ? 3'h0 : uv_cnt + {2'h0, uv_cnt != 3'h7};
        on_cnt <= (sys_rst || !on_any) ? 9'h000 : on_cnt + 9'h001;
    end
    gates_apart_a: assert property (!(first_gate_drive && second_gate_drive))
        else $error("both gates on");
    duty_limit_a: assert property (on_cnt < ON_MAX)
        else $error("gate on too long");
    dead_gap_a: assert property ($rose(second_gate_drive) |-> !$past(first_gate_drive))
        else $error("no gap before second gate");
    undervoltage_lockout_quiet_a: assert property (uv_cnt > 3'h5 |-> !on_any)
        else $error("gate on in lockout");
    fault_off_a: assert property (fault_shutdown && $past(fault_shutdown) |-> !on_any)
        else $error("gate on in fault");
    restart_ref_a: assert property ($fell(fault_shutdown) |-> ##[0:3] soft_start_reference == 11'h000)
        else $error("restart without fresh soft-start");
    ref_ceiling_a: assert property (soft_start_reference <= 11'h4ce)
        else $error("reference above final value");
    trip_stop_a: assert property (on_any && trip |-> ##[1:2] !on_any)
        else $error("gate not ended by trip");
    apb_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    fault_seen_c: cover property ($rose(fault_shutdown));
    restart_seen_c: cover property ($fell(fault_shutdown));
    ss_done_c: cover property (soft_start_reference == 11'h4ce);
endmodule // pps_sequencer_checker
bind pps_sequencer pps_sequencer_checker u_chk (.clk(clk), .sys_rst(sys_rst),
    .undervoltage_lockout(undervoltage_lockout), .current_sense_mv(current_sense_mv),
    .error_amp_mv(error_amp_mv), .psel(psel), .penable(penable), .pready(pready),
    .first_gate_drive(first_gate_drive), .second_gate_drive(second_gate_drive),
    .soft_start_reference(soft_start_reference), .fault_shutdown(fault_shutdown));

// File: testbench/tb_top.sv
// Self-checking bench for the sequencer: registers, gate timing, sync, faults, soft-start.
// Assumes the checker is bound to the design and pps_partner stands on the far side.
`timescale 1ns/1ps
`include "pps_consts.vh"
module tb_top;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg undervoltage_lockout = 1'b0;
    reg [15:0] current_sense_mv = 16'h0000;
    reg [15:0] error_amp_mv = 16'h8000;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h00000000;
    reg sync_on = 1'b0;
    reg [7:0] lfsr = 8'h59;
    reg [31:0] r;
    reg e;
    wire [31:0] prdata;
    wire [10:0] soft_start_reference;
    wire pready, pslverr, first_gate_drive, second_gate_drive, fault_shutdown, irq, ext_sync, shoot;
    integer n_mismatch = 0;
    integer tests_run = 0;
    integer cyc = 0;
    integer i, d, g, o, p, t0;
    pps_sequencer DUT (.clk(clk), .sys_rst(sys_rst), .undervoltage_lockout(undervoltage_lockout),
        .ext_sync(ext_sync), .current_sense_mv(current_sense_mv), .error_amp_mv(error_amp_mv),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .first_gate_drive(first_gate_drive),
        .second_gate_drive(second_gate_drive), .soft_start_reference(soft_start_reference),
        .fault_shutdown(fault_shutdown), .irq(irq));
    pps_partner far (.clk(clk), .sync_on(sync_on), .sync_period(16'h0018),
        .first_gate_drive(first_gate_drive), .second_gate_drive(second_gate_drive),
        .ext_sync(ext_sync), .shoot_through(shoot));
    initial
    begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    function logic [7:0] next_rand();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction
    function integer exp_gap(input integer dt);
        return dt + 1;
    endfunction
    // Soft-start spans 2047 cycle starts; the slack covers the lockout pin filter.
    function logic [31:0] ss_ok(input integer n, input integer per);
        return {31'h0, n >= 2046 * per && n <= 2047 * per + 12};
    endfunction
    function logic pick(input integer s);
        case (s)
            0: return first_gate_drive;
            1: return second_gate_drive;
            2: return fault_shutdown;
            default: return soft_start_reference == `PPS_REF_MV;
        endcase
    endfunction
    task conclude;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
            if (n_mismatch == 0 && tests_run > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task chk(input string n, input [31:0] x, input [31:0] s);
        begin
            tests_run = tests_run + 1;
            if (s !== x)
            begin
                $display("unexpected %s: expected %h, seen %h", n, x, s);
                n_mismatch = n_mismatch + 1;
            end
        end
    endtask
    task apb(input logic w, input [11:0] a, input [31:0] dat);
        integer k;
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= dat;
            @(posedge clk);
            penable <= 1'b1;
            k = 0;
            @(posedge clk);
            while (pready !== 1'b1 && k < 20)
            begin
                @(posedge clk);
                k = k + 1;
            end
            chk("pready", 1, {31'h0, pready});
            if (pready !== 1'b1)
                conclude;
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rd(input string n, input [11:0] a, input [31:0] m, input [31:0] x);
        begin
            apb(1'b0, a, 32'h0);
            chk(n, x, r & m);
        end
    endtask
    task wt(input integer s, input logic v);
        integer k;
        begin
            k = 0;
            @(negedge clk);
            while (pick(s) !== v)
            begin
                @(negedge clk);
                k = k + 1;
                if (k > 10000)
                begin
                    chk("wait bound", 0, 1);
                    conclude;
                end
            end
        end
    endtask
    task meas;
        begin
            wt(0, 0);
            wt(0, 1);
            t0 = cyc;
            wt(0, 0);
            o = cyc - t0;
            g = cyc;
            wt(1, 1);
            g = cyc - g;
            wt(0, 1);
            p = cyc - t0;
        end
    endtask
    task rst;
        begin
            sys_rst <= 1'b1;
            repeat (4) @(posedge clk);
            sys_rst <= 1'b0;
        end
    endtask
    initial
    begin
        rst;
        rd("osc_period", `PPS_OFS_OSC_PERIOD, 32'hffffffff, {16'h0, `PPS_RST_OSC_PERIOD});
        rd("dead_time_setting", `PPS_OFS_DEAD_TIME, 32'hffffffff, {16'h0, `PPS_RST_DEAD_TIME});
        rd("slope_ramp_setting", `PPS_OFS_SLOPE, 32'hffffffff, {16'h0, `PPS_RST_SLOPE});
        rd("bleed_period", `PPS_OFS_BLEED, 32'hffffffff, {16'h0, `PPS_RST_BLEED});
        rd("irq clear", `PPS_OFS_IRQ_CLEAR, 32'hffffffff, 32'h0);
        apb(1'b1, 12'h040, 32'h0000ffff);
        chk("unmapped error", 1, {31'h0, e});
        rd("unmapped read", 12'h040, 32'hffffffff, 32'h0);
        wr_period: apb(1'b1, `PPS_OFS_OSC_PERIOD, 32'h28);
        for (i = 0; i < 4; i = i + 1)
        begin
            d = (i == 0) ? 0 : 3 + (next_rand() % 8);
            apb(1'b1, `PPS_OFS_DEAD_TIME, d);
            meas;
            meas;
            chk("dead gap", exp_gap(d), g);
            chk("on time", 40 - exp_gap(d), o);
            chk("gate period", 80, p);
        end
        sync_on <= 1'b1;
        meas;
        meas;
        chk("synced period", 48, p);
        rd("sync active", `PPS_OFS_STATUS, 32'h80, 32'h80);
        sync_on <= 1'b0;
        for (i = 0; i < 300; i = i + 1)
        begin
            @(posedge clk);
            current_sense_mv <= {7'h0, next_rand(), 1'b0};
            error_amp_mv <= 16'h0640 + {8'h0, next_rand()};
        end
        current_sense_mv <= 16'h0000;
        error_amp_mv <= 16'h8000;
        rst;
        apb(1'b1, `PPS_OFS_OSC_PERIOD, 32'h4);
        apb(1'b1, `PPS_OFS_BLEED, 32'h0);
        apb(1'b1, `PPS_OFS_IRQ_ENABLE, 32'h2);
        @(posedge clk);
        current_sense_mv <= 16'h0190;
        wt(2, 1);
        @(posedge clk);
        current_sense_mv <= 16'h0000;
        apb(1'b0, `PPS_OFS_LEVELS, 32'h0);
        chk("charge steps", 0, r[15:0] % `PPS_FI_STEP);
        chk("shutdown level", 1, {31'h0, r[15:0] >= `PPS_FI_SHUT && r[15:0] < 16'h0b40});
        rd("fault events", `PPS_OFS_IRQ_STATUS, 32'h3, 32'h3);
        chk("irq raised", 1, {31'h0, irq});
        apb(1'b1, `PPS_OFS_IRQ_CLEAR, 32'h2);
        rd("after clear", `PPS_OFS_IRQ_STATUS, 32'h3, 32'h1);
        chk("irq masked", 0, {31'h0, irq});
        apb(1'b1, `PPS_OFS_BLEED, 32'h1);
        wt(2, 0);
        rd("restart event", `PPS_OFS_IRQ_STATUS, 32'h4, 32'h4);
        undervoltage_lockout <= 1'b1;
        rst;
        apb(1'b1, `PPS_OFS_OSC_PERIOD, 32'h4);
        apb(1'b1, `PPS_OFS_IRQ_ENABLE, 32'h8);
        chk("ref in lockout", 0, {21'h0, soft_start_reference});
        chk("gate in lockout", 0, {31'h0, first_gate_drive});
        chk("gate b in lockout", 0, {31'h0, second_gate_drive});
        @(posedge clk);
        undervoltage_lockout <= 1'b0;
        t0 = cyc;
        wt(3, 1);
        chk("soft-start length", 1, ss_ok(cyc - t0, 4));
        repeat (40) @(posedge clk);
        chk("ref hold", {21'h0, `PPS_REF_MV}, {21'h0, soft_start_reference});
        chk("irq on done", 1, {31'h0, irq});
        chk("shoot through", 0, {31'h0, shoot});
        conclude;
    end
endmodule // tb_top
